// ==== verilog/atd_top.sv ====
// execute logic for the accumulator transfer instruction group
module atd_top
	import atd_pkg::*;
(
	// clock, reset, enable
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	// instruction from fetch
	input wire logic instr_valid,
	input wire logic [9:0] instr,
	// source registers, read only
	input wire logic [3:0] wakeup_control_one,
	input wire logic [3:0] wakeup_control_two,
	input wire logic [3:0] clock_mode_register,
	input wire logic [3:0] input_bias_control_zero,
	input wire logic [3:0] input_bias_control_one,
	input wire logic [3:0] converter_control_one,
	input wire logic [3:0] converter_control_two,
	input wire logic [3:0] converter_control_three,
	input wire logic [3:0] interrupt_control_one,
	input wire logic [1:0] conv_result_low,
	input wire logic [2:0] stack_pointer,
	// memory and column register
	input wire logic [3:0] mem_nibble,
	input wire logic [3:0] column_reg,
	output logic mem_rd,
	// register file write back
	output logic acc_we,
	output logic [3:0] acc_wdata,
	output logic col_we,
	output logic [3:0] col_wdata,
	// core status
	output logic carry_we,
	output logic skip_next,
	output logic instr_done
);

	////////////////////////////////////////////////////////////////////////////
	// decode

	atd_dec_if dif ();

	assign dif.opcode = instr;

	atd_decoder u_decoder (
		.dif(dif)
	);

	wire logic take = ce && instr_valid;
	wire logic hit = dif.op != ATD_OP_NONE;
	wire logic is_mem_xor = dif.op == ATD_OP_MEM_XOR;

	////////////////////////////////////////////////////////////////////////////
	// source selection

	wire logic [3:0] conv_low_val = {conv_result_low, 2'b00};
	wire logic [3:0] sp_val = {1'b0, stack_pointer};
	// xor keeps bits where the immediate is zero, so a zero field is a no-op
	wire logic [3:0] col_xor_val = column_reg ^ dif.imm;

	logic [3:0] acc_sel;

	always_comb
	begin
		case (dif.op)
			ATD_OP_WAKEUP_ONE: acc_sel = wakeup_control_one;
			ATD_OP_WAKEUP_TWO: acc_sel = wakeup_control_two;
			ATD_OP_CONV_LOW: acc_sel = conv_low_val;
			ATD_OP_MEM_XOR: acc_sel = mem_nibble;
			ATD_OP_CLOCK_MODE: acc_sel = clock_mode_register;
			ATD_OP_BIAS_ZERO: acc_sel = input_bias_control_zero;
			ATD_OP_BIAS_ONE: acc_sel = input_bias_control_one;
			ATD_OP_CONV_ONE: acc_sel = converter_control_one;
			ATD_OP_CONV_TWO: acc_sel = converter_control_two;
			ATD_OP_CONV_THREE: acc_sel = converter_control_three;
			ATD_OP_STACK_PTR: acc_sel = sp_val;
			ATD_OP_IRQ_ONE: acc_sel = interrupt_control_one;
			default: acc_sel = NIB_RESET;
		endcase
	end

	// memory read is combinational so the nibble is back within the same cycle
	assign mem_rd = take && is_mem_xor;
	// sources other than memory (which has mem_rd) have no read strobe, so reading cannot disturb them
	assign carry_we = 1'b0;
	assign skip_next = 1'b0;

	////////////////////////////////////////////////////////////////////////////
	// write back, one cycle per instruction

	logic acc_we_r;
	logic [3:0] acc_wdata_r;
	logic col_we_r;
	logic [3:0] col_wdata_r;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			acc_we_r <= 1'b0;
			acc_wdata_r <= NIB_RESET;
			col_we_r <= 1'b0;
			col_wdata_r <= NIB_RESET;
		end
		else if (ce)
		begin
			acc_we_r <= instr_valid && hit;
			col_we_r <= instr_valid && is_mem_xor;
			if (instr_valid && hit)
				acc_wdata_r <= acc_sel;
			if (instr_valid && is_mem_xor)
				col_wdata_r <= col_xor_val;
		end
	end

	assign acc_we = acc_we_r;
	assign acc_wdata = acc_wdata_r;
	assign col_we = col_we_r;
	assign col_wdata = col_wdata_r;
	assign instr_done = acc_we_r;

	////////////////////////////////////////////////////////////////////////////
	// checks

	AST_CONV_LOW_HIGH: assert property (@(posedge clk) disable iff (reset)
		(take && instr == OPC_READ_CONV_LOW) |=> (acc_we && acc_wdata[3:2] == $past(conv_result_low)))
		else $error("converter low bits not in accumulator 3:2");

	AST_CONV_LOW_ZERO: assert property (@(posedge clk) disable iff (reset)
		(take && instr == OPC_READ_CONV_LOW) |=> (acc_wdata[1:0] == 2'b00))
		else $error("accumulator 1:0 not cleared on converter low read");

	AST_MEM_LOAD: assert property (@(posedge clk) disable iff (reset)
		(take && (instr & OPC_LOAD_MEM_XOR_MASK) == OPC_LOAD_MEM_XOR_BASE)
		|-> mem_rd ##1 (acc_we && acc_wdata == $past(mem_nibble)))
		else $error("memory nibble not loaded");

	AST_COL_XOR: assert property (@(posedge clk) disable iff (reset)
		(take && (instr & OPC_LOAD_MEM_XOR_MASK) == OPC_LOAD_MEM_XOR_BASE)
		|=> (col_we && col_wdata == ($past(column_reg) ^ $past(instr[3:0]))))
		else $error("column register not xored with immediate");

	// col_we stands while ce is low, so only judge it in the cycle after a live edge
	AST_COL_ONLY_XOR: assert property (@(posedge clk) disable iff (reset)
		(col_we && $past(ce)) |-> (acc_we && (col_wdata ^ $past(instr[3:0])) == $past(column_reg)))
		else $error("column update is not an exclusive or");

	AST_STACK_PTR: assert property (@(posedge clk) disable iff (reset)
		(take && instr == OPC_READ_STACK_PTR) |=> (acc_wdata == {1'b0, $past(stack_pointer)}))
		else $error("stack pointer read wrong");

	AST_CONV_TWO: assert property (@(posedge clk) disable iff (reset)
		(take && instr == 10'h245) |=> (acc_we && acc_wdata == $past(converter_control_two)))
		else $error("converter control two not read");

	AST_CONV_THREE: assert property (@(posedge clk) disable iff (reset)
		(take && instr == OPC_READ_CONV_THREE) |=> (acc_wdata == $past(converter_control_three)))
		else $error("converter control three not read");

	AST_CONV_ONE: assert property (@(posedge clk) disable iff (reset)
		(take && instr == OPC_READ_CONV_ONE) |=> (acc_wdata == $past(converter_control_one)))
		else $error("converter control one not read");

	AST_IRQ_ONE: assert property (@(posedge clk) disable iff (reset)
		(take && instr == 10'h054) |=> (acc_we && acc_wdata == $past(interrupt_control_one)))
		else $error("interrupt control one not read");

	AST_CLOCK_MODE: assert property (@(posedge clk) disable iff (reset)
		(take && instr == OPC_READ_CLOCK_MODE) |=> (acc_wdata == $past(clock_mode_register)))
		else $error("clock mode register not read");

	AST_BIAS: assert property (@(posedge clk) disable iff (reset)
		(take && (instr == OPC_READ_BIAS_ZERO || instr == OPC_READ_BIAS_ONE))
		|=> (acc_wdata == ($past(instr[3]) ? $past(input_bias_control_one) : $past(input_bias_control_zero))))
		else $error("bias control read wrong");

	AST_WAKEUP: assert property (@(posedge clk) disable iff (reset)
		(take && (instr == OPC_READ_WAKEUP_ONE || instr == OPC_READ_WAKEUP_TWO))
		|=> (acc_wdata == ($past(instr[1]) ? $past(wakeup_control_two) : $past(wakeup_control_one))))
		else $error("wakeup control read wrong");

	AST_ONE_CYCLE: assert property (@(posedge clk) disable iff (reset)
		(take && hit) ##1 (ce && !instr_valid) |=> (!acc_we && !skip_next && !carry_we))
		else $error("transfer took more than one cycle");

	// mem_rd follows the word of the current cycle, so it is judged on its own below
	AST_NO_WRITE_IDLE: assert property (@(posedge clk) disable iff (reset)
		(ce && !(instr_valid && hit)) |=> (!acc_we && !col_we))
		else $error("write back without a decoded transfer");

	AST_MEM_RD_TAKE: assert property (@(posedge clk) disable iff (reset)
		mem_rd |-> (ce && instr_valid && (instr & OPC_LOAD_MEM_XOR_MASK) == OPC_LOAD_MEM_XOR_BASE))
		else $error("memory read without a taken memory load");

	AST_COL_NO_OTHER: assert property (@(posedge clk) disable iff (reset)
		(ce && !(instr_valid && (instr & OPC_LOAD_MEM_XOR_MASK) == OPC_LOAD_MEM_XOR_BASE)) |=> !col_we)
		else $error("column written by a transfer other than memory load");

	// a low enable must freeze every registered output, strobes included
	AST_CE_HOLD: assert property (@(posedge clk) disable iff (reset)
		!ce |=> ($stable(acc_we) && $stable(acc_wdata) && $stable(col_we) && $stable(col_wdata)))
		else $error("write back changed while enable low");

endmodule // atd_top

// ==== verilog/atd_pkg.sv ====
// constants and types shared by the accumulator transfer decode block
package atd_pkg;

	localparam int NIB_W = 4;
	localparam int SP_W = 3;
	localparam int CONV_LOW_W = 2;
	localparam int OPC_W = 10;

	localparam logic [9:0] OPC_READ_WAKEUP_ONE = 10'h259;
	localparam logic [9:0] OPC_READ_WAKEUP_TWO = 10'h25a;
	localparam logic [9:0] OPC_READ_CONV_LOW = 10'h249;
	localparam logic [9:0] OPC_READ_CLOCK_MODE = 10'h252;
	localparam logic [9:0] OPC_READ_BIAS_ZERO = 10'h257;
	localparam logic [9:0] OPC_READ_BIAS_ONE = 10'h25e;
	localparam logic [9:0] OPC_READ_CONV_ONE = 10'h244;
	localparam logic [9:0] OPC_READ_CONV_TWO = 10'h245;
	localparam logic [9:0] OPC_READ_CONV_THREE = 10'h246;
	localparam logic [9:0] OPC_READ_STACK_PTR = 10'h050;
	localparam logic [9:0] OPC_READ_IRQ_ONE = 10'h054;
	// memory load with column xor: upper six bits fixed, low nibble immediate
	localparam logic [9:0] OPC_LOAD_MEM_XOR_BASE = 10'h2c0;
	localparam logic [9:0] OPC_LOAD_MEM_XOR_MASK = 10'h3f0;

	localparam logic [3:0] NIB_RESET = 4'h0;

	typedef enum logic [3:0] {
		ATD_OP_NONE,
		ATD_OP_WAKEUP_ONE,
		ATD_OP_WAKEUP_TWO,
		ATD_OP_CONV_LOW,
		ATD_OP_MEM_XOR,
		ATD_OP_CLOCK_MODE,
		ATD_OP_BIAS_ZERO,
		ATD_OP_BIAS_ONE,
		ATD_OP_CONV_ONE,
		ATD_OP_CONV_TWO,
		ATD_OP_CONV_THREE,
		ATD_OP_STACK_PTR,
		ATD_OP_IRQ_ONE
	} atd_op_e;

endpackage

// ==== verilog/atd_dec_if.sv ====
// decode carrier between the opcode decoder and the execute logic
interface atd_dec_if;
	import atd_pkg::*;
	logic [9:0] opcode;
	atd_op_e op;
	logic [3:0] imm;

	modport dec (input opcode, output op, output imm);
	modport exe (output opcode, input op, input imm);
endinterface

// ==== verilog/atd_decoder.sv ====
// opcode decoder for the accumulator transfer group
module atd_decoder
	import atd_pkg::*;
(
	// decode carrier
	atd_dec_if.dec dif
);

	wire mem_xor_hit = (dif.opcode & OPC_LOAD_MEM_XOR_MASK) == OPC_LOAD_MEM_XOR_BASE;

	// one pattern per instruction, each compared over all ten bits except the memory load, which matches the upper six only
	assign dif.op =
		(dif.opcode == OPC_READ_WAKEUP_ONE) ? ATD_OP_WAKEUP_ONE :
		(dif.opcode == OPC_READ_WAKEUP_TWO) ? ATD_OP_WAKEUP_TWO :
		(dif.opcode == OPC_READ_CONV_LOW) ? ATD_OP_CONV_LOW :
		mem_xor_hit ? ATD_OP_MEM_XOR :
		(dif.opcode == OPC_READ_CLOCK_MODE) ? ATD_OP_CLOCK_MODE :
		(dif.opcode == OPC_READ_BIAS_ZERO) ? ATD_OP_BIAS_ZERO :
		(dif.opcode == OPC_READ_BIAS_ONE) ? ATD_OP_BIAS_ONE :
		(dif.opcode == OPC_READ_CONV_ONE) ? ATD_OP_CONV_ONE :
		(dif.opcode == OPC_READ_CONV_TWO) ? ATD_OP_CONV_TWO :
		(dif.opcode == OPC_READ_CONV_THREE) ? ATD_OP_CONV_THREE :
		(dif.opcode == OPC_READ_STACK_PTR) ? ATD_OP_STACK_PTR :
		(dif.opcode == OPC_READ_IRQ_ONE) ? ATD_OP_IRQ_ONE :
		ATD_OP_NONE;

	// immediate field of the memory load sits in the low nibble
	assign dif.imm = dif.opcode[3:0];

endmodule // atd_decoder

// ==== test/tb_top.sv ====
// self-checking bench for the accumulator transfer decode block
module tb_top
	import atd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	////////////////////////////////////////////////////////////////////////////////
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic ce = 1'b1;
	logic instr_valid = 1'b0;
	logic [9:0] instr = 10'h000;
	logic [3:0] wakeup_control_one = 4'h1;
	logic [3:0] wakeup_control_two = 4'h2;
	logic [3:0] clock_mode_register = 4'h3;
	logic [3:0] input_bias_control_zero = 4'h4;
	logic [3:0] input_bias_control_one = 4'ha;
	logic [3:0] converter_control_one = 4'h6;
	logic [3:0] converter_control_two = 4'hb;
	logic [3:0] converter_control_three = 4'hd;
	logic [3:0] interrupt_control_one = 4'h9;
	logic [1:0] conv_result_low = 2'h3;
	logic [2:0] stack_pointer = 3'h7;
	logic [3:0] mem_nibble = 4'h0;
	logic [3:0] column_reg = 4'ha;
	logic mem_rd, acc_we, col_we, carry_we, skip_next, instr_done;
	logic [3:0] acc_wdata, col_wdata;
	int mismatches = 0;
	int n_checks = 0;

	// distinct source values so a wrong select shows up
	localparam logic [9:0] RD_OPS [11] = '{OPC_READ_WAKEUP_ONE, OPC_READ_WAKEUP_TWO, OPC_READ_CLOCK_MODE,
		OPC_READ_BIAS_ZERO, OPC_READ_BIAS_ONE, OPC_READ_CONV_ONE, OPC_READ_CONV_TWO, OPC_READ_CONV_THREE,
		OPC_READ_IRQ_ONE, OPC_READ_CONV_LOW, OPC_READ_STACK_PTR};
	localparam logic [3:0] RD_EXP [11] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'ha, 4'h6, 4'hb, 4'hd, 4'h9, 4'hc, 4'h7};

	atd_top dut (.clk, .reset, .ce, .instr_valid, .instr, .wakeup_control_one, .wakeup_control_two,
		.clock_mode_register, .input_bias_control_zero, .input_bias_control_one, .converter_control_one,
		.converter_control_two, .converter_control_three, .interrupt_control_one, .conv_result_low,
		.stack_pointer, .mem_nibble, .column_reg, .mem_rd, .acc_we, .acc_wdata, .col_we, .col_wdata,
		.carry_we, .skip_next, .instr_done);

	initial
	begin
		forever #2.5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// present a new word, then judge it and the result of the word before
	task automatic step(input logic [9:0] opc, input logic v, input logic [3:0] mem, input logic rd,
		input logic we, input logic [3:0] acc, input logic cwe, input logic [3:0] col);
		@(posedge clk);
		instr <= opc;
		instr_valid <= v;
		mem_nibble <= mem;
		#1;
		chk({3'h0, mem_rd}, {3'h0, rd});
		chk({3'h0, acc_we}, {3'h0, we});
		chk({3'h0, instr_done}, {3'h0, we});
		chk({3'h0, col_we}, {3'h0, cwe});
		chk({2'h0, carry_we, skip_next}, 4'h0);
		if (we)
			chk(acc_wdata, acc);
		if (cwe)
			chk(col_wdata, col);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic test_reads();
		for (int i = 0; i <= 11; i++)
			step(RD_OPS[i % 11], i < 11, 4'h0, 1'b0, i > 0, RD_EXP[(i + 10) % 11], 1'b0, 4'h0);
		$display("test reads done");
	endtask

	task automatic test_mem_xor();
		logic [3:0] j;
		for (int i = 0; i <= 16; i++)
		begin
			j = i[3:0];
			step(OPC_LOAD_MEM_XOR_BASE | {6'h00, j}, i < 16, ~j, i < 16, i > 0, ~(j - 4'h1), i > 0, 4'ha ^ (j - 4'h1));
		end
		$display("test mem_xor done");
	endtask

	task automatic test_refused();
		step(10'h253, 1'b1, 4'h0, 1'b0, 1'b0, 4'h0, 1'b0, 4'h0);
		step(10'h2d5, 1'b1, 4'h0, 1'b0, 1'b0, 4'h0, 1'b0, 4'h0);
		step(OPC_READ_CONV_ONE, 1'b0, 4'h0, 1'b0, 1'b0, 4'h0, 1'b0, 4'h0);
		step(10'h000, 1'b0, 4'h0, 1'b0, 1'b0, 4'h0, 1'b0, 4'h0);
		// last write was the memory load with immediate f: nibble 0, column a ^ f
		chk(acc_wdata, 4'h0);
		chk(col_wdata, 4'h5);
		// frozen core: a valid word is not taken while ce is low
		@(posedge clk);
		ce <= 1'b0;
		instr <= OPC_LOAD_MEM_XOR_BASE;
		instr_valid <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk({mem_rd, acc_we, col_we, 1'b0}, 4'h0);
		chk(col_wdata, 4'h5);
		@(posedge clk);
		ce <= 1'b1;
		instr_valid <= 1'b0;
		$display("test refused done");
	endtask

	task automatic test_reset();
		step(OPC_READ_BIAS_ONE, 1'b1, 4'h0, 1'b0, 1'b0, 4'h0, 1'b0, 4'h0);
		@(posedge clk);
		instr_valid <= 1'b0;
		#1;
		reset = 1'b1;
		#1;
		chk({acc_we, col_we, instr_done, mem_rd}, 4'h0);
		chk(acc_wdata, 4'h0);
		chk(col_wdata, 4'h0);
		@(posedge clk);
		reset <= 1'b0;
		step(OPC_READ_STACK_PTR, 1'b1, 4'h0, 1'b0, 1'b0, 4'h0, 1'b0, 4'h0);
		step(10'h000, 1'b0, 4'h0, 1'b0, 1'b1, 4'h7, 1'b0, 4'h0);
		$display("test reset done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (5) @(posedge clk);
		chk({acc_we, col_we, instr_done, mem_rd}, 4'h0);
		reset <= 1'b0;
		test_reads();
		test_mem_xor();
		test_refused();
		test_reset();
		stop_test();
	end

	// run needs well under a hundred cycles
	initial
	begin
		#5000;
		mismatches++;
		stop_test();
	end
endmodule // tb_top
